// file: core/buhde_device.sv
// Device end of the host data exchange: buffers, return codes and serial link slave.
// Assumes a bus layer on the same clock that reports frame events as one-cycle pulses.
//
// What this block does
// - Continue command resends all master bytes from the first
// - Host loads count and bytes, then slave command
// - Slave tx start posts code 0H with irq
// - Host writes later slave bytes before fetch
// - All bytes sent posts code 2H with irq
// - Transmit error posts code 3H with irq
// - Slave byte N fetched no earlier than N slots
// - Status and lock replies go out automatically
// - Master rx stores header, posts start, irq
// - Master reception start code is 4H
// - Each received byte appended to read buffer
// - Master rx 20 bytes posts 5H with irq
// - Master rx frame done posts 6H with irq
// - Master rx error posts 7H with irq
// - Master rx header readable at start code
// - Slave rx header stored, posts 8H with irq
// - Slave rx 20 bytes posts 9H with irq
// - Slave rx frame done posts AH with irq
// - Slave rx error posts BH with irq
// - Slave and broadcast header readable at start
// - Broadcast header stored, posts CH with irq
// - Broadcast full DH, end EH, error FH
// - Each new code overwrites the return code
// - Interrupt request drives the irq line high
//
// The Avalon-MM interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module buhde_device #(
  parameter int unsigned BYTE_CYC_M0 = buhde_pkg::BYTE_CYC_M0, // Slot length in mode 0.
  parameter int unsigned BYTE_CYC_M1 = buhde_pkg::BYTE_CYC_M1, // Slot length in mode 1.
  parameter int unsigned BYTE_CYC_M2 = buhde_pkg::BYTE_CYC_M2  // Slot length in mode 2.
) (
  input wire logic i_clk,             // System clock.
  input wire logic i_reset,           // Synchronous reset, active high.
  buhde_link_if.dev link,             // Serial link to the controller.
  input wire logic [1:0] i_mode,      // Bus speed mode of the frame.
  input wire logic i_ctrl_valid,      // Control bits received as slave.
  input wire logic [3:0] i_ctrl_bits, // Received control bits.
  input wire logic i_arb_won,         // Master address field won.
  input wire logic i_hdr_valid,       // Message length field acknowledged.
  input wire logic i_hdr_bcast,       // Header belongs to a broadcast.
  input wire logic [7:0] i_hdr_addr,  // Address of the far unit.
  input wire logic [3:0] i_hdr_ctrl,  // Control bits of the frame.
  input wire logic [7:0] i_hdr_len,   // Message length in bytes.
  input wire logic i_rx_valid,        // One data byte received.
  input wire logic [7:0] i_rx_byte,   // Received data byte.
  input wire logic i_tx_fetch,        // Bus layer wants the next byte.
  input wire logic i_tx_sent,         // One byte sent correctly.
  input wire logic i_comm_error,      // Frame halted by an error.
  output logic o_cmd_valid,           // Command pulse to the bus layer.
  output logic [3:0] o_cmd_code,      // Command code.
  output logic [3:0] o_cmd_ctrl,      // Control bits for a master request.
  output logic o_tx_valid,            // Transmit byte pulse.
  output logic [7:0] o_tx_byte,       // Transmit byte.
  output logic o_auto_reply           // Send status or lock address now.
);

  function automatic logic [4:0] rbuf_inc(input logic [4:0] p);
    return (p == buhde_pkg::RBUF_LAST) ? 5'h00 : p + 5'h01;
  endfunction

  function automatic logic [3:0] rx_base(input buhde_pkg::buhde_role_t r);
    case (r)
      buhde_pkg::ST_SRX: return buhde_pkg::RET_SRX_START;
      buhde_pkg::ST_BRX: return buhde_pkg::RET_BRX_START;
      default: return buhde_pkg::RET_MRX_START;
    endcase
  endfunction

  // ****************************************************************
  // Link sampling and framing.
  // ****************************************************************
  logic [2:0] sck_s_r;
  logic [2:0] sel_s_r;
  logic [1:0] si_s_r;
  logic [4:0] bit_cnt_r;
  logic [7:0] in_sh_r;
  logic [1:0] op_r;
  logic [7:0] ans_sh_r;
  logic so_r;
  logic [7:0] in_byte;
  logic sel_on;
  logic rise;
  logic fall;
  logic byte0_done;
  logic frame_done;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sck_s_r <= 3'h7;
      sel_s_r <= 3'h7;
      si_s_r <= 2'h0;
    end else begin
      sck_s_r <= {sck_s_r[1:0], link.sck};
      sel_s_r <= {sel_s_r[1:0], link.sel_n};
      si_s_r <= {si_s_r[0], link.si};
    end
  end

  assign sel_on = ~sel_s_r[1];
  assign rise = sck_s_r[1] & ~sck_s_r[2];
  assign fall = ~sck_s_r[1] & sck_s_r[2];
  assign in_byte = {in_sh_r[6:0], si_s_r[1]};
  assign byte0_done = sel_on & rise & (bit_cnt_r == buhde_pkg::BYTE0_LAST_BIT);
  assign frame_done = sel_on & rise & (bit_cnt_r == buhde_pkg::FRAME_LAST_BIT);

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      bit_cnt_r <= 5'h00;
      in_sh_r <= 8'h00;
      op_r <= 2'h0;
    end else if (!sel_on) begin
      bit_cnt_r <= 5'h00;
    end else if (rise) begin
      in_sh_r <= in_byte;
      bit_cnt_r <= bit_cnt_r + 5'h01;
      if (byte0_done) begin
        op_r <= in_byte[7:6];
      end
    end
  end

  // ****************************************************************
  // Buffers and return code.
  // ****************************************************************
  logic [7:0] wbuf [buhde_pkg::WBUF_DEPTH];
  logic [4:0] wbuf_wp_r;
  logic [7:0] rbuf [buhde_pkg::RBUF_DEPTH];
  logic [4:0] rbuf_wp_r;
  logic [4:0] rbuf_rp_r;
  logic [4:0] fill_r;
  logic [7:0] rx_cnt_r;
  logic [7:0] rx_len_r;
  logic [3:0] ret_code_r;
  logic irq_r;
  logic ret_read;
  logic rbuf_pop;
  logic cmd_hit;

  assign ret_read = byte0_done & (in_byte[7:6] == buhde_pkg::OP_READ_RET);
  assign rbuf_pop = byte0_done & (in_byte[7:6] == buhde_pkg::OP_READ_RBUF);
  assign cmd_hit = frame_done & (op_r == buhde_pkg::OP_COMMAND);

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ans_sh_r <= 8'h00;
      so_r <= 1'b0;
    end else if (byte0_done) begin
      ans_sh_r <= ret_read ? {4'h0, ret_code_r} : (rbuf_pop ? rbuf[rbuf_rp_r] : 8'h00);
    end else if (sel_on && fall && bit_cnt_r >= buhde_pkg::FRAME_BITS - 5'h08) begin
      so_r <= ans_sh_r[7];
      ans_sh_r <= {ans_sh_r[6:0], 1'b0};
    end
  end

  // ****************************************************************
  // Role sequencing.
  // ****************************************************************
  buhde_pkg::buhde_role_t role_r;
  buhde_pkg::buhde_role_t role_nxt;
  logic post_en;
  logic [3:0] post_code;
  logic take_m;
  logic take_s;
  logic hdr_store;
  logic rx_store;
  logic tx_over;
  logic [7:0] tx_len_r;
  logic [7:0] tx_sent_r;

  always_comb begin
    role_nxt = role_r;
    post_en = 1'b0;
    post_code = ret_code_r;
    take_m = 1'b0;
    take_s = 1'b0;
    hdr_store = 1'b0;
    rx_store = 1'b0;
    tx_over = 1'b0;
    case (role_r)
      buhde_pkg::ST_MPEND_TX: begin
        if (i_comm_error) begin
          {post_en, post_code, tx_over} = {1'b1, buhde_pkg::RET_TX_TERM, 1'b1};
          role_nxt = buhde_pkg::ST_IDLE;
        end else if (i_arb_won) begin
          {post_en, post_code} = {1'b1, buhde_pkg::RET_TX_START};
          role_nxt = buhde_pkg::ST_MTX;
        end
      end
      buhde_pkg::ST_MPEND_RX: begin
        if (i_comm_error) begin
          {post_en, post_code} = {1'b1, buhde_pkg::RET_MRX_START | buhde_pkg::RET_OFS_ABORT};
          role_nxt = buhde_pkg::ST_IDLE;
        end else if (i_hdr_valid) begin
          {post_en, post_code, hdr_store} = {1'b1, buhde_pkg::RET_MRX_START, 1'b1};
          role_nxt = buhde_pkg::ST_MRX;
        end
      end
      buhde_pkg::ST_MTX, buhde_pkg::ST_STX: begin
        if (i_comm_error) begin
          {post_en, post_code, tx_over} = {1'b1, buhde_pkg::RET_TX_TERM, 1'b1};
          role_nxt = buhde_pkg::ST_IDLE;
        end else if (i_tx_sent && tx_sent_r + 8'h01 >= tx_len_r) begin
          {post_en, post_code, tx_over} = {1'b1, buhde_pkg::RET_TX_END, 1'b1};
          role_nxt = buhde_pkg::ST_IDLE;
        end
      end
      buhde_pkg::ST_MRX, buhde_pkg::ST_SRX, buhde_pkg::ST_BRX: begin
        if (i_comm_error) begin
          {post_en, post_code} = {1'b1, rx_base(role_r) | buhde_pkg::RET_OFS_ABORT};
          role_nxt = buhde_pkg::ST_IDLE;
        end else if (i_rx_valid) begin
          rx_store = 1'b1;
          if (rx_cnt_r + 8'h01 >= rx_len_r) begin
            {post_en, post_code} = {1'b1, rx_base(role_r) | buhde_pkg::RET_OFS_END};
            role_nxt = buhde_pkg::ST_IDLE;
          end else if (fill_r == buhde_pkg::RBUF_LAST) begin
            {post_en, post_code} = {1'b1, rx_base(role_r) | buhde_pkg::RET_OFS_FULL};
          end
        end
      end
      default: begin
        if (i_hdr_valid && i_hdr_bcast) begin
          {post_en, post_code, hdr_store} = {1'b1, buhde_pkg::RET_BRX_START, 1'b1};
          role_nxt = buhde_pkg::ST_BRX;
        end else if (i_hdr_valid && buhde_pkg::CTRL_SRX_SET[i_hdr_ctrl]) begin
          {post_en, post_code, hdr_store} = {1'b1, buhde_pkg::RET_SRX_START, 1'b1};
          role_nxt = buhde_pkg::ST_SRX;
        end else if (role_r == buhde_pkg::ST_STX_ARMED && i_ctrl_valid && buhde_pkg::CTRL_STX_SET[i_ctrl_bits]) begin
          {post_en, post_code} = {1'b1, buhde_pkg::RET_TX_START};
          role_nxt = buhde_pkg::ST_STX;
        end else if (cmd_hit && (in_byte[3:0] == buhde_pkg::CMD_MASTER_REQUEST_FIRST || in_byte[3:0] == buhde_pkg::CMD_MASTER_REQUEST_CONTINUE)) begin
          take_m = 1'b1;
          role_nxt = wbuf[0][buhde_pkg::CTRL_TX_BIT] ? buhde_pkg::ST_MPEND_TX : buhde_pkg::ST_MPEND_RX;
        end else if (cmd_hit && in_byte[3:0] == buhde_pkg::CMD_SLAVE_DATA_LOAD) begin
          take_s = 1'b1;
          role_nxt = buhde_pkg::ST_STX_ARMED;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      role_r <= buhde_pkg::ST_IDLE;
      ret_code_r <= buhde_pkg::RET_RESET;
      irq_r <= 1'b0;
    end else begin
      role_r <= role_nxt;
      if (post_en) begin
        ret_code_r <= post_code;
      end
      if (post_en) begin
        irq_r <= 1'b1;
      end else if (ret_read) begin
        irq_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wbuf_wp_r <= 5'h00;
    end else if (tx_over || (take_m && !wbuf[0][buhde_pkg::CTRL_TX_BIT])) begin
      wbuf_wp_r <= 5'h00;
    end else if (frame_done && op_r == buhde_pkg::OP_WBUF_WRITE) begin
      wbuf[wbuf_wp_r] <= in_byte;
      wbuf_wp_r <= wbuf_wp_r + 5'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      {rbuf_wp_r, rbuf_rp_r, fill_r, rx_cnt_r, rx_len_r} <= '0;
    end else begin
      if (hdr_store) begin
        rbuf[0] <= i_hdr_addr;
        rbuf[1] <= {4'h0, i_hdr_ctrl};
        rbuf[2] <= i_hdr_len;
        {rbuf_wp_r, fill_r, rx_cnt_r, rx_len_r} <= {buhde_pkg::RBUF_HDR_BYTES, 5'h00, 8'h00, i_hdr_len};
      end else if (rx_store) begin
        rbuf[rbuf_wp_r] <= i_rx_byte;
        rbuf_wp_r <= rbuf_inc(rbuf_wp_r);
        fill_r <= rbuf_inc(fill_r);
        rx_cnt_r <= rx_cnt_r + 8'h01;
      end
      if (hdr_store) begin
        rbuf_rp_r <= 5'h00;
      end else if (rbuf_pop) begin
        rbuf_rp_r <= rbuf_inc(rbuf_rp_r);
      end
    end
  end

  // ****************************************************************
  // Transmit fetch with slave slot pacing.
  // ****************************************************************
  logic [4:0] tx_idx_r;
  logic [7:0] fetch_n_r;
  logic [7:0] slot_r;
  logic [31:0] slot_tmr_r;
  logic [31:0] slot_len;
  logic fetch_pend_r;
  logic fetch_go;
  logic tx_role;

  assign tx_role = (role_r == buhde_pkg::ST_MTX) || (role_r == buhde_pkg::ST_STX);
  assign slot_len = (i_mode == 2'h0) ? BYTE_CYC_M0 : ((i_mode == 2'h1) ? BYTE_CYC_M1 : BYTE_CYC_M2);
  assign fetch_go = fetch_pend_r && (role_r == buhde_pkg::ST_MTX || fetch_n_r < slot_r);

  always_ff @(posedge i_clk) begin
    if (i_reset || role_r != buhde_pkg::ST_STX) begin
      slot_tmr_r <= 32'h0000_0000;
      slot_r <= 8'h00;
    end else if (slot_tmr_r + 32'h0000_0001 >= slot_len) begin
      slot_tmr_r <= 32'h0000_0000;
      slot_r <= (slot_r == 8'hFF) ? slot_r : slot_r + 8'h01;
    end else begin
      slot_tmr_r <= slot_tmr_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      {tx_idx_r, fetch_n_r, tx_len_r, tx_sent_r, fetch_pend_r} <= '0;
      {o_tx_valid, o_tx_byte, o_cmd_valid, o_cmd_code, o_cmd_ctrl, o_auto_reply} <= '0;
    end else begin
      o_cmd_valid <= take_m | take_s;
      o_cmd_code <= in_byte[3:0];
      o_auto_reply <= i_ctrl_valid & buhde_pkg::CTRL_AUTO_SET[i_ctrl_bits];
      if (take_m) begin
        o_cmd_ctrl <= wbuf[0][3:0];
        {tx_len_r, tx_idx_r, tx_sent_r, fetch_n_r} <= {wbuf[1], buhde_pkg::WBUF_MASTER_DATA, 16'h0000};
      end else if (take_s) begin
        {tx_len_r, tx_idx_r, tx_sent_r, fetch_n_r} <= {wbuf[0], buhde_pkg::WBUF_SLAVE_DATA, 16'h0000};
      end
      if (i_tx_sent && tx_role) begin
        tx_sent_r <= tx_sent_r + 8'h01;
      end
      o_tx_valid <= fetch_go;
      if (fetch_go) begin
        o_tx_byte <= wbuf[tx_idx_r];
        tx_idx_r <= tx_idx_r + 5'h01;
        fetch_n_r <= fetch_n_r + 8'h01;
        fetch_pend_r <= 1'b0;
      end else if (!tx_role) begin
        fetch_pend_r <= 1'b0;
      end else if (i_tx_fetch) begin
        fetch_pend_r <= 1'b1;
      end
    end
  end

  assign link.so = so_r;
  assign link.irq = irq_r;

endmodule // buhde_device
`default_nettype wire

// file: core/buhde_host.sv
// Controller end of the host data exchange: Avalon-MM slave that runs link frames.
// Assumes software writes one frame at a time and polls status for busy and answer.
`timescale 1ns/1ps
`default_nettype none
module buhde_host (
  input wire logic i_clk,                  // System clock.
  input wire logic i_reset,                // Synchronous reset, active high.
  buhde_link_if.host link,                 // Serial link to the device.
  input wire logic [3:0] i_avs_address,    // Byte address of the register.
  input wire logic i_avs_read,             // Read request.
  input wire logic i_avs_write,            // Write request.
  input wire logic [31:0] i_avs_writedata, // Write data.
  output logic [31:0] o_avs_readdata,      // Read data.
  output logic o_avs_waitrequest,          // Stall, active high.
  output logic o_irq                       // Device interrupt, synchronised.
);

  logic [1:0] so_s_r;
  logic [1:0] irq_s_r;
  logic busy_r;
  logic sck_r;
  logic sel_n_r;
  logic si_r;
  logic [3:0] half_r;
  logic [4:0] bits_r;
  logic [15:0] tx_sh_r;
  logic [7:0] rx_sh_r;
  logic [7:0] ans_r;
  logic start;
  logic [31:0] status;

  // ****************************************************************
  // Pin sampling.
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      so_s_r <= 2'h0;
      irq_s_r <= 2'h0;
    end else begin
      so_s_r <= {so_s_r[0], link.so};
      irq_s_r <= {irq_s_r[0], link.irq};
    end
  end

  // ****************************************************************
  // Frame engine.
  // ****************************************************************
  // A frame write stalls while the previous frame is busy, so later transmit bytes reach the device
  // only once the current frame has ended.
  assign start = o_avs_waitrequest & i_avs_write & (i_avs_address == buhde_pkg::REG_FRAME) & ~busy_r;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      {busy_r, si_r, half_r, bits_r, tx_sh_r, rx_sh_r, ans_r} <= '0;
      sck_r <= 1'b1;
      sel_n_r <= 1'b1;
    end else if (start) begin
      busy_r <= 1'b1;
      sel_n_r <= 1'b0;
      half_r <= 4'h0;
      bits_r <= 5'h00;
      tx_sh_r <= {i_avs_writedata[buhde_pkg::FRAME_OP_LSB +: 2], 6'h00, i_avs_writedata[7:0]};
    end else if (busy_r && half_r == buhde_pkg::SCK_HALF_LAST) begin
      half_r <= 4'h0;
      if (sck_r && bits_r == buhde_pkg::FRAME_BITS) begin
        busy_r <= 1'b0;
        sel_n_r <= 1'b1;
        ans_r <= rx_sh_r;
      end else if (sck_r) begin
        sck_r <= 1'b0;
        si_r <= tx_sh_r[15];
        tx_sh_r <= {tx_sh_r[14:0], 1'b0};
      end else begin
        sck_r <= 1'b1;
        rx_sh_r <= {rx_sh_r[6:0], so_s_r[1]};
        bits_r <= bits_r + 5'h01;
      end
    end else if (busy_r) begin
      half_r <= half_r + 4'h1;
    end
  end

  // ****************************************************************
  // Avalon-MM slave.
  // ****************************************************************
  always_comb begin
    status = 32'h0000_0000;
    status[buhde_pkg::STAT_BUSY_BIT] = busy_r;
    status[buhde_pkg::STAT_IRQ_BIT] = irq_s_r[1];
    status[buhde_pkg::STAT_ANS_LSB +: 8] = ans_r;
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0000_0000;
    end else if (!o_avs_waitrequest) begin
      o_avs_waitrequest <= 1'b1;
    end else if (i_avs_read) begin
      o_avs_waitrequest <= 1'b0;
      o_avs_readdata <= (i_avs_address == buhde_pkg::REG_STATUS) ? status : 32'h0000_0000;
    end else if (i_avs_write && !(i_avs_address == buhde_pkg::REG_FRAME && busy_r)) begin
      o_avs_waitrequest <= 1'b0;
    end
  end

  assign o_irq = irq_s_r[1];
  assign link.sck = sck_r;
  assign link.sel_n = sel_n_r;
  assign link.si = si_r;

endmodule // buhde_host
`default_nettype wire

// file: core/buhde_link_if.sv
// Serial host link between the controller end and the device end.
// Assumes both ends run on the same system clock; the link is sampled, not clocked.
`timescale 1ns/1ps
`default_nettype none
interface buhde_link_if;
  logic sck;
  logic sel_n;
  logic si;
  logic so;
  logic irq;
  modport host (output sck, output sel_n, output si, input so, input irq);
  modport dev (input sck, input sel_n, input si, output so, output irq);
endinterface
`default_nettype wire

// file: core/buhde_pkg.sv
// Shared constants and types for the host data exchange of the serial bus controller.
// Assumes a 20 MHz system clock shared by both ends of the serial host link.
package buhde_pkg;

  // ****************************************************************
  // Timing.
  // ****************************************************************
  localparam int CLK_MHZ = 20;
  localparam int BYTE_US_M0 = 1580;
  localparam int BYTE_US_M1 = 400;
  localparam int BYTE_US_M2 = 290;
  localparam int BYTE_CYC_M0 = BYTE_US_M0 * CLK_MHZ;
  localparam int BYTE_CYC_M1 = BYTE_US_M1 * CLK_MHZ;
  localparam int BYTE_CYC_M2 = BYTE_US_M2 * CLK_MHZ;
  localparam logic [3:0] SCK_HALF_LAST = 4'h7;
  localparam logic [4:0] FRAME_LAST_BIT = 5'h0F;
  localparam logic [4:0] BYTE0_LAST_BIT = 5'h07;
  localparam logic [4:0] FRAME_BITS = 5'h10;

  // ****************************************************************
  // Buffers.
  // ****************************************************************
  localparam int RBUF_DEPTH = 20;
  localparam logic [4:0] RBUF_LAST = 5'h13;
  localparam logic [4:0] RBUF_HDR_BYTES = 5'h03;
  localparam int WBUF_DEPTH = 32;
  localparam logic [4:0] WBUF_SLAVE_DATA = 5'h01;
  localparam logic [4:0] WBUF_MASTER_DATA = 5'h02;

  // ****************************************************************
  // Link operations and commands.
  // ****************************************************************
  localparam logic [1:0] OP_WBUF_WRITE = 2'h0;
  localparam logic [1:0] OP_COMMAND = 2'h1;
  localparam logic [1:0] OP_READ_RET = 2'h2;
  localparam logic [1:0] OP_READ_RBUF = 2'h3;
  localparam logic [3:0] CMD_MASTER_REQUEST_FIRST = 4'h2;
  localparam logic [3:0] CMD_MASTER_REQUEST_CONTINUE = 4'h3;
  localparam logic [3:0] CMD_SLAVE_DATA_LOAD = 4'h5;
  localparam int CTRL_TX_BIT = 3;
  localparam logic [15:0] CTRL_AUTO_SET = 16'h0071;
  localparam logic [15:0] CTRL_STX_SET = 16'h0088;
  localparam logic [15:0] CTRL_SRX_SET = 16'hCC00;

  // ****************************************************************
  // Return codes.
  // ****************************************************************
  localparam logic [3:0] RET_TX_START = 4'h0;
  localparam logic [3:0] RET_TX_END = 4'h2;
  localparam logic [3:0] RET_TX_TERM = 4'h3;
  localparam logic [3:0] RET_MRX_START = 4'h4;
  localparam logic [3:0] RET_SRX_START = 4'h8;
  localparam logic [3:0] RET_BRX_START = 4'hC;
  localparam logic [3:0] RET_OFS_FULL = 4'h1;
  localparam logic [3:0] RET_OFS_END = 4'h2;
  localparam logic [3:0] RET_OFS_ABORT = 4'h3;
  localparam logic [3:0] RET_RESET = 4'h0;

  // ****************************************************************
  // Controller registers on the Avalon side.
  // ****************************************************************
  localparam logic [3:0] REG_FRAME = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int FRAME_OP_LSB = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_IRQ_BIT = 1;
  localparam int STAT_ANS_LSB = 8;

  typedef enum logic [3:0] {
    ST_IDLE, ST_MPEND_TX, ST_MPEND_RX, ST_MTX, ST_STX_ARMED, ST_STX, ST_MRX, ST_SRX, ST_BRX
  } buhde_role_t;

endpackage

// file: test/buhde_link_checker.sv
// Link checker for the host data exchange.
// Assumes the link signals and the shared system clock as plain inputs.
`timescale 1ns/1ps
`default_nettype none
module buhde_link_checker (
  input wire logic i_clk, // Clock.
  input wire logic i_reset, // Reset.
  input wire logic sck, // Link clock.
  input wire logic sel_n, // Frame select.
  input wire logic si, // Host data.
  input wire logic so, // Device data.
  input wire logic irq // Interrupt.
);
  logic sck_r;
  logic [4:0] rise_r;
  always_ff @(posedge i_clk) sck_r <= sck;
  always_ff @(posedge i_clk) begin
    if (i_reset || sel_n) begin
      rise_r <= 5'h00;
    end else if (sck && !sck_r) begin
      rise_r <= rise_r + 5'h01;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  sequence low_half;
    !sck [*8] ##1 sck;
  endsequence
  a_sck_idle_high: assert property (sel_n |-> sck) else $error("link clock not idle high");
  a_sel_gap_two: assert property ($rose(sel_n) |=> sel_n) else $error("select gap too short");
  a_sck_low_half: assert property ($fell(sck) |-> low_half) else $error("low half wrong");
  a_sck_high_half: assert property ($rose(sck) |-> sck [*8]) else $error("high half short");
  a_si_held_high: assert property (sck && $past(sck) && !sel_n && !$fell(sel_n) |-> $stable(si))
    else $error("data moved while clock high");
  a_so_low_only: assert property ($changed(so) |-> !sck) else $error("answer moved while high");
  a_irq_clear_frame: assert property ($fell(irq) |-> !sel_n) else $error("irq cleared idle");
  a_frame_sixteen: assert property ($rose(sel_n) |-> rise_r == 5'h10) else $error("not 16 bits");
endmodule // buhde_link_checker
`default_nettype wire

// file: test/test_bus_unit_host_data_exchange.sv
// Testbench for both ends of the host data exchange joined by the link.
// Assumes shortened slot lengths and a bus layer played by bench pulses.
`timescale 1ns/1ps
`default_nettype none
module test_bus_unit_host_data_exchange;
  logic i_clk, i_reset, rd_w, wr_w, bc, wait_rq, irq_h, cmd_v, tx_v, auto_r;
  logic [3:0] ad, ctl, hctl, cmd_code, cmd_ctrl;
  logic [31:0] wd, rdata, rd;
  logic [7:0] haddr, hlen, rxb, tx_byte, last_tx, last_cmd, d;
  logic [6:0] p;
  logic [1:0] md;
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  int autos = 0;
  buhde_link_if link();
  buhde_device #(.BYTE_CYC_M0(40), .BYTE_CYC_M1(20), .BYTE_CYC_M2(16)) buhde_device_inst (
    .i_clk(i_clk), .i_reset(i_reset), .link(link), .i_mode(md), .i_ctrl_valid(p[0]),
    .i_ctrl_bits(ctl), .i_arb_won(p[1]), .i_hdr_valid(p[2]), .i_hdr_bcast(bc),
    .i_hdr_addr(haddr), .i_hdr_ctrl(hctl), .i_hdr_len(hlen), .i_rx_valid(p[3]),
    .i_rx_byte(rxb), .i_tx_fetch(p[4]), .i_tx_sent(p[5]), .i_comm_error(p[6]),
    .o_cmd_valid(cmd_v), .o_cmd_code(cmd_code), .o_cmd_ctrl(cmd_ctrl), .o_tx_valid(tx_v),
    .o_tx_byte(tx_byte), .o_auto_reply(auto_r));
  buhde_host buhde_host_inst (.i_clk(i_clk), .i_reset(i_reset), .link(link),
    .i_avs_address(ad), .i_avs_read(rd_w), .i_avs_write(wr_w), .i_avs_writedata(wd),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wait_rq), .o_irq(irq_h));
  buhde_link_checker buhde_link_checker_inst (.i_clk(i_clk), .i_reset(i_reset),
    .sck(link.sck), .sel_n(link.sel_n), .si(link.si), .so(link.so), .irq(link.irq));
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  task complete_run();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cmd_v) last_cmd <= {cmd_code, cmd_ctrl};
    if (tx_v) last_tx <= tx_byte;
    if (auto_r) autos <= autos + 1;
    if (cyc == 60000) begin
      err_total++;
      complete_run();
    end
  end
  task ck(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD at %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task av(input logic w, input logic [3:0] a, input logic [31:0] x);
    @(posedge i_clk);
    {wr_w, rd_w, ad, wd} <= {w, !w, a, x};
    @(posedge i_clk);
    while (wait_rq !== 1'b0) @(posedge i_clk);
    rd = rdata;
    {wr_w, rd_w} <= 2'h0;
  endtask
  task fr(input logic [1:0] op, input logic [7:0] b);
    av(1'b1, 4'h0, {22'h0, op, b});
    rd = 32'h1;
    while (rd[0] !== 1'b0) av(1'b0, 4'h4, 32'h0);
  endtask
  task pu(input logic [6:0] m);
    @(posedge i_clk);
    p <= m;
    @(posedge i_clk);
    p <= 7'h00;
  endtask
  task rc(input logic [3:0] c);
    repeat (4) @(posedge i_clk);
    av(1'b0, 4'h4, 32'h0);
    ck({7'h0, rd[1]}, 8'h01);
    fr(2'h2, 8'h00);
    ck(rd[15:8], {4'h0, c});
  endtask
  task rx(input logic [3:0] b, input logic [3:0] hc, input logic bcast, input logic [7:0] len,
          input int n, input logic e);
    logic [23:0] hdr;
    hdr = {8'($urandom), 4'h0, hc, len};
    {bc, hctl, haddr, hlen} <= {bcast, hc, hdr[23:16], len};
    pu(7'h04);
    rc(b);
    for (int k = 0; k < 3; k++) begin
      fr(2'h3, 8'h00);
      ck(rd[15:8], hdr[23 - 8 * k -: 8]);
    end
    for (int i = 0; i < n; i++) begin
      rxb <= 8'($urandom);
      pu(7'h08);
      if (i == 0) fr(2'h3, 8'h00);
      if (i == 0) ck(rd[15:8], rxb);
      if (i == 19 && len != 8'h14) rc(b + 4'h1);
    end
    if (e) pu(7'h40);
    rc(b + (e ? 4'h3 : 4'h2));
    $display("receive case %0h done", b);
  endtask
  initial begin
    {i_reset, p, rd_w, wr_w, ad, wd, ctl, bc, hctl, haddr, hlen, rxb} = '0;
    md = 2'h2;
    i_reset = 1'b1;
    void'($urandom(32'hB30B5788));
    repeat (4) @(posedge i_clk);
    i_reset <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      ctl <= 4'(k);
      pu(7'h01);
    end
    repeat (2) @(posedge i_clk);
    ck(8'(autos), 8'h04);
    fr(2'h0, 8'h03);
    fr(2'h1, 8'h02);
    rx(4'h4, 4'h3, 1'b0, 8'h02, 1, 1'b1);
    fr(2'h0, 8'h05);
    fr(2'h1, 8'h02);
    rx(4'h4, 4'h5, 1'b0, 8'h15, 21, 1'b0);
    rx(4'h8, 4'hA, 1'b0, 8'h19, 20, 1'b1);
    rx(4'h8, 4'hE, 1'b0, 8'h03, 3, 1'b0);
    rx(4'hC, 4'hF, 1'b1, 8'h14, 20, 1'b0);
    rx(4'hC, 4'hB, 1'b1, 8'h15, 20, 1'b1);
    d = 8'($urandom);
    for (int k = 0; k < 2; k++) begin
      fr(2'h0, 8'h0A);
      fr(2'h0, 8'h01);
      fr(2'h0, d);
      fr(2'h1, 8'h02 + 8'(k));
      ck(last_cmd, 8'h2A + 8'(k << 4));
      pu(7'h02);
      rc(4'h0);
      pu(k ? 7'h10 : 7'h40);
      if (k) pu(7'h20);
      rc(k ? 4'h2 : 4'h3);
    end
    ck(last_tx, d);
    fr(2'h0, 8'h01);
    fr(2'h0, ~d);
    fr(2'h1, 8'h05);
    ctl <= 4'h7;
    md <= 2'($urandom_range(2));
    pu(7'h01);
    pu(7'h10);
    ck(last_tx, d);
    rc(4'h0);
    pu(7'h20);
    rc(4'h2);
    ck(last_tx, ~d);
    $display("transmit cases done");
    complete_run();
  end
endmodule // test_bus_unit_host_data_exchange
`default_nettype wire
